// ### logic/csfr_fault_bit.sv
// One latched fault flag: set by a hardware event, cleared by write-one or power cycle.
// Assumes all inputs except sys_rst are synchronous to mclk.
`timescale 1ns/1ps
`default_nettype none
module csfr_fault_bit
   import csfr_pkg::*;
(
   input wire logic mclk, // System clock
   input wire logic sys_rst, // Asynchronous reset, high
   input wire logic clkEn, // Freezes state while low
   input wire logic faultEvent, // Hardware fault detected
   input wire logic writeOneClr, // Host wrote one to this bit
   input wire logic powerClr, // Input power was cycled
   output logic fault_q // Latched fault flag
);
   logic fault_d; // Next flag value

   // Next value: a new event wins over any clear in the same cycle
   always_comb begin
      fault_d = fault_q;
      if (faultEvent) begin
         fault_d = 1'b1;
      end else if (writeOneClr || powerClr) begin
         fault_d = 1'b0;
      end
   end

   // Flag register, resets to no fault
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         fault_q <= 1'b0;
      end else if (clkEn) begin
         fault_q <= fault_d;
      end
   end

   // Event sets the flag even when a clear arrives together
   a_fault_sets: assert property (@(posedge mclk) disable iff (sys_rst)
      clkEn && faultEvent |=> fault_q)
      else $error("fault flag not set by event");
   // Clear without event drops the flag
   a_fault_clears: assert property (@(posedge mclk) disable iff (sys_rst)
      clkEn && !faultEvent && (writeOneClr || powerClr) |=> !fault_q)
      else $error("fault flag not cleared");
   // No clear and no event keeps the flag for two cycles
   a_fault_holds: assert property (@(posedge mclk) disable iff (sys_rst)
      !faultEvent && !writeOneClr && !powerClr ##1 !faultEvent && !writeOneClr && !powerClr
      |=> fault_q == $past(fault_q, 2))
      else $error("fault flag changed without cause");
endmodule // csfr_fault_bit
`default_nettype wire

// ### logic/csfr_pkg.sv
// Constants for the charger status and latched fault register group.
// Assumes byte-wide registers reached through an external serial register port.
package csfr_pkg;
   // Register addresses
   localparam logic [7:0] ADDR_CHG_STATE_REPORT = 8'h0B;
   localparam logic [7:0] ADDR_BATT_THERM_REPORT = 8'h0C;
   localparam logic [7:0] ADDR_LATCHED_FAULTS = 8'h0D;
   // Field positions, charger state report
   localparam int BIT_INPUT_OV = 7;
   localparam int BIT_INPUT_VALID = 6;
   localparam int BIT_INPUT_ILIM = 5;
   localparam int BIT_DIE_HEAT_LIM = 4;
   localparam int BIT_CHG_FINISHED = 3;
   // Three-bit code fields: low field in both reports, zone field in the second
   localparam int FIELD_CODE_MSB = 2;
   localparam int FIELD_CODE_LSB = 0;
   localparam int FIELD_ZONE_MSB = 7;
   localparam int FIELD_ZONE_LSB = 5;
   // Field positions, battery and thermal report
   localparam int BIT_RECHARGE_NEEDED = 3;
   // Field positions, latched faults
   localparam int BIT_BATT_SHORT = 3;
   localparam int BIT_OVERTEMP_LOW = 1;
   localparam int BIT_OVERTEMP_HIGH = 0;
   // Charger state codes
   localparam logic [2:0] CHG_OFF = 3'h0;
   localparam logic [2:0] CHG_TRICKLE = 3'h1;
   localparam logic [2:0] CHG_FAST_CC = 3'h2;
   localparam logic [2:0] CHG_FAST_CV = 3'h3;
   localparam logic [2:0] CHG_COMPLETE = 3'h4;
   localparam logic [2:0] CHG_LDO = 3'h5;
   localparam logic [2:0] CHG_TIMER_EXPIRED = 3'h6;
   localparam logic [2:0] CHG_BATT_DETECT = 3'h7;
   // Thermistor zone and battery band codes
   localparam logic [2:0] THERM_OFF = 3'h0;
   localparam logic [2:0] THERM_COLD = 3'h1;
   localparam logic [2:0] THERM_COOL = 3'h2;
   localparam logic [2:0] THERM_WARM = 3'h3;
   localparam logic [2:0] THERM_HOT = 3'h4;
   localparam logic [2:0] THERM_NORMAL = 3'h7;
   localparam logic [2:0] BATT_MON_OFF = 3'h0;
   localparam logic [2:0] BATT_ABSENT = 3'h1;
   localparam logic [2:0] BATT_BELOW_DEAD = 3'h2;
   localparam logic [2:0] BATT_DEAD_TO_WEAK = 3'h3;
   localparam logic [2:0] BATT_ABOVE_WEAK = 3'h4;
   // Reset values
   localparam logic [7:0] READ_DATA_RESET = 8'h00;
   localparam logic [2:0] CODE_RESET = 3'h0;
endpackage : csfr_pkg

// ### logic/csfr_regs.sv
// Charger status and latched fault registers, read and written through a byte register port.
// Assumes a serial front end outside decodes host frames into regAddr with one-cycle strobes,
// and that analog comparators and the charger controller supply synchronous status inputs.
// Notes on behaviour
// - Status bits report overvoltage and valid input
// - Status bit shows input current limiting
// - Status bit shows die temperature limiting
// - Charge-finished bit latches past recharge threshold
// - Three-bit field reports charger state code
// - Upper bits report thermistor zone code
// - Recharge flag only when disabled and complete
// - Recharge flag one when battery below threshold
// - Three-bit field reports battery voltage band
// - Battery short fault latches, resets zero
// - Two over-temperature fault levels latch separately
// - Fault cleared by write-one or power cycle
// - Mode change sets interrupt flag when enabled
`timescale 1ns/1ps
`default_nettype none
module csfr_regs
   import csfr_pkg::*;
(
   input wire logic mclk, // System clock, 100 MHz
   input wire logic sys_rst, // Asynchronous reset, high
   input wire logic clkEn, // Freezes all state while low
   input wire logic [7:0] regAddr, // Register address
   input wire logic regWrEn, // Write strobe, one cycle
   input wire logic [7:0] regWrData, // Write data
   input wire logic regRdEn, // Read strobe, one cycle
   output logic [7:0] regRdData_q, // Read data, valid cycle after strobe
   input wire logic inputOvervoltageFlag, // Input above overvoltage threshold
   input wire logic inputValidFlag, // Input above valid thresholds
   input wire logic inputCurrentLimitedFlag, // Input current restricted by blocking device
   input wire logic dieHeatLimitedFlag, // Charge current cut by die temperature
   input wire logic [2:0] chargerStateCode, // Charger controller state
   input wire logic [2:0] thermistorZoneCode, // Thermistor zone
   input wire logic batteryBelowRecharge, // Battery below recharge threshold
   input wire logic autoRechargeDisable, // Automatic recharge switched off
   input wire logic [2:0] batteryBandCode, // Battery voltage band
   input wire logic batteryShortEvent, // Battery short detected
   input wire logic dieOvertempLowEvent, // Lower over-temperature level reached
   input wire logic dieOvertempHighEvent, // Higher over-temperature level reached
   input wire logic inputPowerCycled, // Pulse after input power returns
   input wire logic modeChangeIrqEnable, // Mode change interrupt enabled
   input wire logic modeChangeIrqClear, // Clear of the mode change flag
   output logic modeChangeIrqFlag_q, // Mode change interrupt flag
   output logic [7:0] latchedFaults_q // Current fault register image
);
   // Sampled status inputs, derived flags, next values and register images
   logic inputOv_q, inputOv_d; // Overvoltage
   logic inputValid_q, inputValid_d; // Valid input
   logic inputIlim_q, inputIlim_d; // Current limited
   logic dieHeat_q, dieHeat_d; // Thermal limited
   logic [2:0] chgState_q, chgState_d; // Charger state
   logic [2:0] thermZone_q, thermZone_d; // Thermistor zone
   logic [2:0] battBand_q, battBand_d; // Battery band
   logic rechargeNeeded_q, rechargeNeeded_d; // Recharge flag
   logic chargeFinished_q, chargeFinished_d; // End of charge latch
   logic modeChangeIrqFlag_d; // Next interrupt flag
   logic [7:0] regRdData_d; // Next read data
   logic [7:0] latchedFaults_d; // Fault image
   logic [7:0] chgReport; // Charger state report image
   logic [7:0] battReport; // Battery and thermal report image
   logic faultWrite; // Write to fault register
   logic battShort_q, overtempLow_q, overtempHigh_q; // Fault flags

   // Write strobe decode for the fault register only; status registers ignore writes
   assign faultWrite = regWrEn && (regAddr == ADDR_LATCHED_FAULTS);

   // Fault flags, one latch each
   // write-one clear
   csfr_fault_bit uBattShort (.mclk(mclk), .sys_rst(sys_rst), .clkEn(clkEn),
      .faultEvent(batteryShortEvent), .writeOneClr(faultWrite && regWrData[BIT_BATT_SHORT]),
      .powerClr(inputPowerCycled), .fault_q(battShort_q));
   csfr_fault_bit uOvertempLow (.mclk(mclk), .sys_rst(sys_rst), .clkEn(clkEn),
      .faultEvent(dieOvertempLowEvent), .writeOneClr(faultWrite && regWrData[BIT_OVERTEMP_LOW]),
      .powerClr(inputPowerCycled), .fault_q(overtempLow_q));
   csfr_fault_bit uOvertempHigh (.mclk(mclk), .sys_rst(sys_rst), .clkEn(clkEn),
      .faultEvent(dieOvertempHighEvent), .writeOneClr(faultWrite && regWrData[BIT_OVERTEMP_HIGH]),
      .powerClr(inputPowerCycled), .fault_q(overtempHigh_q));

   // Register images built from the held state
   always_comb begin
      chgReport = 8'h00;
      chgReport[BIT_INPUT_OV] = inputOv_q;
      chgReport[BIT_INPUT_VALID] = inputValid_q;
      chgReport[BIT_INPUT_ILIM] = inputIlim_q;
      chgReport[BIT_DIE_HEAT_LIM] = dieHeat_q;
      chgReport[BIT_CHG_FINISHED] = chargeFinished_q;
      chgReport[FIELD_CODE_MSB:FIELD_CODE_LSB] = chgState_q;
      battReport = 8'h00;
      battReport[FIELD_ZONE_MSB:FIELD_ZONE_LSB] = thermZone_q;
      battReport[BIT_RECHARGE_NEEDED] = rechargeNeeded_q;
      battReport[FIELD_CODE_MSB:FIELD_CODE_LSB] = battBand_q;
      latchedFaults_d = 8'h00;
      latchedFaults_d[BIT_OVERTEMP_LOW] = overtempLow_q;
      latchedFaults_d[BIT_OVERTEMP_HIGH] = overtempHigh_q;
      latchedFaults_d[BIT_BATT_SHORT] = battShort_q;
   end

   // Next status state
   always_comb begin
      inputOv_d = inputOvervoltageFlag;
      inputValid_d = inputValidFlag;
      inputIlim_d = inputCurrentLimitedFlag;
      dieHeat_d = dieHeatLimitedFlag;
      chgState_d = chargerStateCode;
      thermZone_d = thermistorZoneCode;
      battBand_d = batteryBandCode;
      rechargeNeeded_d = autoRechargeDisable && (chargerStateCode == CHG_COMPLETE) && batteryBelowRecharge;
      chargeFinished_d = chargeFinished_q;
      case (chargerStateCode)
         CHG_COMPLETE: begin
            chargeFinished_d = 1'b1;
         end
         // A new charge cycle drops the latch
         CHG_TRICKLE, CHG_FAST_CC, CHG_FAST_CV: begin
            chargeFinished_d = 1'b0;
         end
         // Other states hold it, recharge threshold ignored
         default: begin
            chargeFinished_d = chargeFinished_q;
         end
      endcase
      if (inputPowerCycled) begin
         chargeFinished_d = 1'b0;
      end
      modeChangeIrqFlag_d = modeChangeIrqFlag_q;
      if (modeChangeIrqEnable && (chargerStateCode != chgState_q)) begin
         modeChangeIrqFlag_d = 1'b1;
      end else if (modeChangeIrqClear) begin
         modeChangeIrqFlag_d = 1'b0;
      end
   end

   // Status registers
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         inputOv_q <= 1'b0;
         inputValid_q <= 1'b0;
         inputIlim_q <= 1'b0;
         dieHeat_q <= 1'b0;
         chgState_q <= CODE_RESET;
         thermZone_q <= CODE_RESET;
         battBand_q <= CODE_RESET;
         rechargeNeeded_q <= 1'b0;
         chargeFinished_q <= 1'b0;
         modeChangeIrqFlag_q <= 1'b0;
      end else if (clkEn) begin
         inputOv_q <= inputOv_d;
         inputValid_q <= inputValid_d;
         inputIlim_q <= inputIlim_d;
         dieHeat_q <= dieHeat_d;
         chgState_q <= chgState_d;
         thermZone_q <= thermZone_d;
         battBand_q <= battBand_d;
         rechargeNeeded_q <= rechargeNeeded_d;
         chargeFinished_q <= chargeFinished_d;
         modeChangeIrqFlag_q <= modeChangeIrqFlag_d;
      end
   end

   // Read mux; reads change nothing but the read data
   // no read side effects
   always_comb begin
      regRdData_d = regRdData_q;
      if (regRdEn) begin
         case (regAddr)
            ADDR_CHG_STATE_REPORT: regRdData_d = chgReport;
            ADDR_BATT_THERM_REPORT: regRdData_d = battReport;
            ADDR_LATCHED_FAULTS: regRdData_d = latchedFaults_d;
            // Unmapped addresses read zero
            default: regRdData_d = READ_DATA_RESET;
         endcase
      end
   end

   // Read data and fault image registers
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         regRdData_q <= READ_DATA_RESET;
         latchedFaults_q <= READ_DATA_RESET;
      end else if (clkEn) begin
         regRdData_q <= regRdData_d;
         latchedFaults_q <= latchedFaults_d;
      end
   end

   a_ov_valid_read: assert property (@(posedge mclk) disable iff (sys_rst)
      clkEn && regRdEn && regAddr == ADDR_CHG_STATE_REPORT
      |=> regRdData_q[7:6] == $past({inputOv_q, inputValid_q}))
      else $error("input voltage bits misreported");
   a_ilim_track: assert property (@(posedge mclk) disable iff (sys_rst)
      clkEn && inputCurrentLimitedFlag |=> inputIlim_q)
      else $error("current limit bit not shown");
   a_heat_track: assert property (@(posedge mclk) disable iff (sys_rst)
      clkEn && !dieHeatLimitedFlag |=> !dieHeat_q)
      else $error("thermal limit bit stuck");
   a_finish_holds: assert property (@(posedge mclk) disable iff (sys_rst)
      clkEn && chargerStateCode == CHG_COMPLETE ##1 clkEn && chargerStateCode == CHG_COMPLETE
      && !inputPowerCycled |=> chargeFinished_q)
      else $error("charge finished latch dropped");
   a_state_field: assert property (@(posedge mclk) disable iff (sys_rst)
      clkEn && regRdEn && regAddr == ADDR_CHG_STATE_REPORT |=> regRdData_q[2:0] == $past(chgState_q))
      else $error("charger state field wrong");
   a_therm_band: assert property (@(posedge mclk) disable iff (sys_rst)
      clkEn && regRdEn && regAddr == ADDR_BATT_THERM_REPORT
      |=> regRdData_q[7:5] == $past(thermZone_q) && regRdData_q[2:0] == $past(battBand_q))
      else $error("thermistor or battery field wrong");
   a_recharge_gate: assert property (@(posedge mclk) disable iff (sys_rst)
      clkEn && (!autoRechargeDisable || chargerStateCode != CHG_COMPLETE) |=> !rechargeNeeded_q)
      else $error("recharge flag active outside its mode");
   a_recharge_value: assert property (@(posedge mclk) disable iff (sys_rst)
      clkEn && autoRechargeDisable && chargerStateCode == CHG_COMPLETE
      |=> rechargeNeeded_q == $past(batteryBelowRecharge))
      else $error("recharge flag value wrong");
   a_irq_on_change: assert property (@(posedge mclk) disable iff (sys_rst)
      clkEn && modeChangeIrqEnable && chargerStateCode != chgState_q |=> modeChangeIrqFlag_q)
      else $error("mode change flag not set");
   a_zero_write_keeps: assert property (@(posedge mclk) disable iff (sys_rst)
      clkEn && faultWrite && regWrData == 8'h00 && !inputPowerCycled && !batteryShortEvent
      |=> battShort_q == $past(battShort_q))
      else $error("zero write changed fault bit");
endmodule // csfr_regs
`default_nettype wire

// ### test/csfr_host_model.sv
// Host side of the register port: issues single-byte reads and writes.
// Assumes the registers take a strobe on the rising mclk edge after it is raised.
`timescale 1ns/1ps
`default_nettype none
module csfr_host_model (
   input wire logic mclk, // System clock
   input wire logic [7:0] regRdData_q, // Read data from the registers
   output var logic [7:0] regAddr, // Register address
   output var logic regWrEn, // Write strobe
   output var logic [7:0] regWrData, // Write data
   output var logic regRdEn // Read strobe
);
   // Quiet port at time zero
   initial begin
      regAddr = 8'h00;
      regWrEn = 1'b0;
      regWrData = 8'h00;
      regRdEn = 1'b0;
   end
   // Read: strobe held to the taking edge, answer picked up after it
   task automatic hostRead(input logic [7:0] addr, output logic [7:0] data);
      @(posedge mclk);
      #1;
      regAddr = addr;
      regRdEn = 1'b1;
      @(posedge mclk);
      #1;
      data = regRdData_q;
      regRdEn = 1'b0;
      regAddr = ~addr; // Released address shows no stale value
   endtask
   task automatic hostWrite(input logic [7:0] addr, input logic [7:0] data);
      @(posedge mclk);
      #1;
      regAddr = addr;
      regWrData = data;
      regWrEn = 1'b1;
      @(posedge mclk);
      #1;
      regWrEn = 1'b0;
      regAddr = ~addr; // Released lines inverted
      regWrData = ~data;
   endtask
endmodule // csfr_host_model
`default_nettype wire

// ### test/testbench.sv
// Self-checking bench for the charger status and fault registers.
// Assumes csfr_pkg, csfr_regs and csfr_host_model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module testbench
   import csfr_pkg::*;
;
   logic mclk = 1'b0; // System clock
   logic sys_rst = 1'b1; // Reset, high
   logic clkEn = 1'b1; // Clock enable to the design
   logic [7:0] regAddr, regWrData, regRdData_q, latchedFaults_q, rd, fltM;
   logic regWrEn, regRdEn, irqFlag, finM;
   logic ov, valid, ilim, heat, below, dis, shortEv, lowEv, highEv, pwrCyc, irqEn, irqClr;
   logic [2:0] state, therm, band;
   logic [2:0] zones [6] = '{THERM_OFF, THERM_COLD, THERM_COOL, THERM_WARM, THERM_HOT, THERM_NORMAL};
   int badCount = 0; // Mismatches seen
   int checksDone = 0; // Comparisons made
   // 100 MHz clock
   always #5 mclk = ~mclk;
   csfr_regs i_dut (.mclk, .sys_rst, .clkEn, .regAddr, .regWrEn, .regWrData, .regRdEn,
      .regRdData_q, .inputOvervoltageFlag(ov), .inputValidFlag(valid), .inputCurrentLimitedFlag(ilim),
      .dieHeatLimitedFlag(heat), .chargerStateCode(state), .thermistorZoneCode(therm),
      .batteryBelowRecharge(below), .autoRechargeDisable(dis), .batteryBandCode(band),
      .batteryShortEvent(shortEv), .dieOvertempLowEvent(lowEv), .dieOvertempHighEvent(highEv),
      .inputPowerCycled(pwrCyc), .modeChangeIrqEnable(irqEn), .modeChangeIrqClear(irqClr),
      .modeChangeIrqFlag_q(irqFlag), .latchedFaults_q);
   csfr_host_model i_host (.mclk, .regRdData_q, .regAddr, .regWrEn, .regWrData, .regRdEn);
   // Compare one value
   task automatic checkVal(input logic [7:0] seen, input logic [7:0] exp);
      checksDone++;
      if (seen !== exp) begin
         badCount++;
         $display("MISMATCH t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask
   // Verdict and end of run
   task automatic tallyAndFinish();
      if (badCount == 0 && checksDone > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // Let n edges pass, then step off the edge
   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   // Read a register and compare with the model
   task automatic readCheck(input logic [7:0] addr, input logic [7:0] exp);
      i_host.hostRead(addr, rd);
      checkVal(rd, exp);
   endtask
   // Model images of the two status registers
   function automatic logic [7:0] img1();
      return {ov, valid, ilim, heat, finM, state};
   endfunction
   function automatic logic [7:0] img2();
      return {therm, 1'b0, dis & below & (state == CHG_COMPLETE), band};
   endfunction
   // Hang guard
   initial begin
      #200000;
      badCount++;
      tallyAndFinish();
   end
   // Main sequence
   initial begin
      {ov, valid, ilim, heat, below, dis, shortEv, lowEv, highEv, pwrCyc, irqEn, irqClr} = 12'h000;
      {state, therm, band} = 9'h000;
      finM = 1'b0;
      fltM = 8'h00;
      void'($urandom(32'h9d95));
      repeat (4) @(posedge mclk);
      #1;
      sys_rst = 1'b0;
      readCheck(ADDR_LATCHED_FAULTS, 8'h00);
      // Walk every charger state, zone and band code with random flags
      for (int i = 0; i < 24; i++) begin
         {ov, valid, ilim, heat, irqEn} = 5'($urandom);
         state = 3'(i % 8);
         therm = zones[i % 6];
         band = 3'(i % 5);
         {dis, below} = (state == CHG_COMPLETE) ? 2'((i >> 3) + 1) : 2'($urandom);
         if (state == CHG_COMPLETE) finM = 1'b1;
         else if (state inside {CHG_TRICKLE, CHG_FAST_CC, CHG_FAST_CV}) finM = 1'b0;
         tick(3);
         checkVal({7'h00, irqFlag}, {7'h00, irqEn & (i > 0)});
         irqClr = 1'b1;
         tick(1);
         irqClr = 1'b0;
         checkVal({7'h00, irqFlag}, 8'h00);
         readCheck(ADDR_CHG_STATE_REPORT, img1());
         readCheck(ADDR_BATT_THERM_REPORT, img2());
         readCheck(ADDR_CHG_STATE_REPORT, img1());
      end
      // Leave the finished latch set ahead of the power cycle
      state = CHG_COMPLETE;
      tick(3);
      state = CHG_LDO;
      finM = 1'b1;
      // Battery short and upper over-temperature events
      {shortEv, highEv} = 2'b11;
      fltM = fltM | 8'h09;
      tick(1);
      {shortEv, highEv} = 2'b00;
      tick(2);
      checkVal(latchedFaults_q, fltM);
      readCheck(ADDR_LATCHED_FAULTS, fltM);
      i_host.hostWrite(ADDR_LATCHED_FAULTS, 8'h00);
      tick(1);
      checkVal(latchedFaults_q, fltM);
      i_host.hostWrite(ADDR_LATCHED_FAULTS, 8'h01);
      fltM = fltM & ~8'h01;
      tick(1);
      checkVal(latchedFaults_q, fltM);
      lowEv = 1'b1;
      fltM = fltM | 8'h02;
      tick(1);
      lowEv = 1'b0;
      tick(2);
      readCheck(ADDR_LATCHED_FAULTS, fltM);
      // Read-only and unmapped places
      i_host.hostWrite(ADDR_CHG_STATE_REPORT, 8'hFF);
      readCheck(ADDR_CHG_STATE_REPORT, img1());
      readCheck(8'h0E, 8'h00);
      // Power cycle clears faults and the finished latch
      pwrCyc = 1'b1;
      tick(1);
      pwrCyc = 1'b0;
      finM = 1'b0;
      fltM = 8'h00;
      tick(2);
      checkVal(latchedFaults_q, fltM);
      readCheck(ADDR_CHG_STATE_REPORT, img1());
      // Frozen clock enable must ignore a fault event
      clkEn = 1'b0;
      shortEv = 1'b1;
      tick(1);
      shortEv = 1'b0;
      tick(1);
      clkEn = 1'b1;
      checkVal(latchedFaults_q, fltM);
      readCheck(ADDR_LATCHED_FAULTS, fltM);
      tallyAndFinish();
   end
endmodule // testbench
`default_nettype wire
